// ---- inc/jsu_defines.svh ----
// constants for the jtag security unlock and debug rom block
`ifndef JSU_DEFINES_SVH
`define JSU_DEFINES_SVH

`define JSU_CODE_W        128
// factory visible code, tie-offs and reference; values are arbitrary
`define JSU_FACTORY_CODE  128'hffff_ffff_ffff_ffff_ffff_ffff_ffff_ffff
`define JSU_TIE_OFF       128'h5a3c_96e1_0f78_c3a5_1e2d_4b87_f069_d2b4
`define JSU_REFERENCE     (`JSU_FACTORY_CODE ^ `JSU_TIE_OFF)

// instruction register
`define JSU_IR_CAPTURE    4'h1
`define JSU_IR_BSCAN      4'h0
`define JSU_IR_IDCODE     4'h1
`define JSU_IR_ROUTER_ID  4'h2
`define JSU_IR_ROUTE      4'h7
`define JSU_IR_UNLOCK     4'hb
`define JSU_IR_BYPASS     4'hf

// top bit index of each data register
`define JSU_MSB_BYPASS    7'h00
`define JSU_MSB_IDCODE    7'h1f
`define JSU_MSB_ROUTE     7'h05
`define JSU_MSB_BSCAN     7'h07
`define JSU_MSB_UNLOCK    7'h7f

// route register layout
`define JSU_N_SEC         4
`define JSU_ROUTE_LEN     6
`define JSU_ROUTE_TEST    4
`define JSU_ROUTE_BSC     5
`define JSU_ROUTE_RESET   6'h00
`define JSU_SEC_SECURE    4'h4
`define JSU_BSC_LEN       8

// debug apb frames
`define JSU_FRAME_MASK    32'hffff_f000
`define JSU_ROM_BASE      32'hffa0_0000
`define JSU_CPU_BASE      32'hffa0_1000
`define JSU_ROM_IDX_CPU   10'h000
`define JSU_ROM_IDX_RSVA  10'h001
`define JSU_ROM_IDX_RSVB  10'h002
`define JSU_ROM_IDX_OVL   10'h003
`define JSU_ROM_IDX_END   10'h004
`define JSU_ROM_VAL_CPU   32'h0000_1003
`define JSU_ROM_VAL_RSVA  32'h0000_2002
`define JSU_ROM_VAL_RSVB  32'h0000_3002
`define JSU_ROM_VAL_OVL   32'h0000_4003
`define JSU_ROM_VAL_END   32'h0000_0000

`endif

// ---- inc/jsu_pkg.sv ----
// types for the jtag security unlock and debug rom block
`include "jsu_defines.svh"
package jsu_pkg;
    typedef enum logic [3:0] {
        tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_sh_dr,
        tap_ex1_dr, tap_pa_dr, tap_ex2_dr, tap_upd_dr, tap_sel_ir,
        tap_cap_ir, tap_sh_ir, tap_ex1_ir, tap_pa_ir, tap_ex2_ir,
        tap_upd_ir
    } jsu_tap_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } jsu_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } jsu_apb_rsp_type;

    typedef struct packed {
        jsu_tap_type                tap;
        logic [3:0]                 ir_shift;
        logic [3:0]                 ir;
        logic [`JSU_CODE_W-1:0]     dr;
        logic [`JSU_ROUTE_LEN-1:0]  route;
        logic [`JSU_BSC_LEN-1:0]    bsc_out;
        logic                       tck_prev;
        logic                       tdo;
        logic                       tdo_oe;
        logic                       grant;
        logic [`JSU_N_SEC-1:0]      sec_en;
        logic                       test_en;
        logic                       bscan_en;
        jsu_apb_rsp_type            rsp;
        logic                       rom_sel;
        logic                       cpu_sel;
    } jsu_state_type;
endpackage

// ---- src/jsu_sync.sv ----
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module jsu_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } jsu_sync_state_type;

    jsu_sync_state_type s_reg;
    jsu_sync_state_type s_next;

    always_comb begin
        s_next.first  = async_in;
        s_next.second = s_reg.first;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.second;
endmodule // jsu_sync

// ---- src/jsu_top.sv ----
// jtag security unlock, tap route gating and debug rom frames
// Functional notes
// RULE1 - xor otp code with scan register, tie-offs
// RULE2 - full 128-bit match against reference grants unlock
// RULE3 - factory code unlocks with empty scan register
// RULE4 - programmer secures by clearing a code bit
// RULE5 - all-zero visible code stays locked forever
// RULE6 - instruction 0b1011 selects unlock scan register
// RULE7 - debugger scans xor restoring factory code
// RULE8 - unlock register cleared only by power-on
// RULE9 - secured: only security chain via tap two
// RULE10 - secured: other, test, boundary taps blocked
// RULE11 - two 4KB frames, unimplemented reads zero
// RULE12 - rom words point to debug components
// RULE13 - jtag id equals router id register
// RULE14 - boundary data shifts tdi to tdo
// RULE15 - grant follows unlock update at once
`timescale 1ns/10ps
module jsu_top
    import jsu_pkg::*;
#(
    parameter logic [31:0] ID_CODE = 32'h0000_1001 // arbitrary value
) (
    // clock and resets
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    input  wire logic                     power_on_reset_n,
    // jtag pins
    input  wire logic                     tck,
    input  wire logic                     tms,
    input  wire logic                     tdi,
    output logic                          tdo,
    output logic                          tdo_oe,
    // one-time-programmable visible code
    input  wire logic [`JSU_CODE_W-1:0]   visible_unlock_code,
    // tap router gating
    output logic                          unlock_grant,
    output logic [`JSU_N_SEC-1:0]         sec_tap_enable,
    output logic                          test_tap_enable,
    output logic                          bscan_enable,
    // boundary cells
    input  wire logic [`JSU_BSC_LEN-1:0]  bsc_pin_in,
    output logic      [`JSU_BSC_LEN-1:0]  bsc_pin_out,
    // debug apb
    input  wire jsu_apb_req_type          apb_req,
    output jsu_apb_rsp_type               apb_rsp,
    output logic                          debug_rom_frame_select,
    output logic                          cpu_debug_frame_select
);
    localparam jsu_state_type S_INIT = '{tap: tap_reset,
        ir: `JSU_IR_IDCODE, route: `JSU_ROUTE_RESET, default: '0};

    ////////////////////////////////////////////////////////////////////
    // reset release
    logic       rst_any_n;
    logic [1:0] rst_pipe;
    logic [1:0] por_pipe;
    logic       rst_q;
    logic       por_q;

    assign rst_any_n = rst_n & power_on_reset_n;

    always_ff @(posedge clock or negedge rst_any_n) begin
        if (!rst_any_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    always_ff @(posedge clock or negedge power_on_reset_n) begin
        if (!power_on_reset_n) begin
            por_pipe <= 2'h0;
        end else begin
            por_pipe <= {por_pipe[0], 1'b1};
        end
    end

    assign rst_q = rst_pipe[1];
    assign por_q = por_pipe[1];

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [`JSU_BSC_LEN+2:0] pins_q;
    logic                    tck_q;
    logic                    tms_q;
    logic                    tdi_q;
    logic [`JSU_BSC_LEN-1:0] bsc_q;

    jsu_sync #(.WIDTH(`JSU_BSC_LEN + 3)) u_sync (
        .clock    (clock),
        .rst_n    (rst_q),
        .async_in ({bsc_pin_in, tdi, tms, tck}),
        .sync_out (pins_q)
    );

    assign tck_q = pins_q[0];
    assign tms_q = pins_q[1];
    assign tdi_q = pins_q[2];
    assign bsc_q = pins_q[`JSU_BSC_LEN+2:3];

    ////////////////////////////////////////////////////////////////////
    // state
    jsu_state_type          s_reg;
    jsu_state_type          s_next;
    logic [`JSU_CODE_W-1:0] unlock_reg;
    logic [`JSU_CODE_W-1:0] unlock_next;
    logic [`JSU_CODE_W-1:0] combined;
    logic                   match;
    logic                   tck_rise;
    logic                   tck_fall;
    logic [3:0]             eff_ir;
    logic [6:0]             msb;
    logic                   setup;
    logic                   rom_hit;
    logic                   cpu_hit;

    function automatic jsu_tap_type tap_step(input jsu_tap_type t,
                                             input logic m);
        case (t)
            tap_reset:  tap_step = m ? tap_reset  : tap_idle;
            tap_idle:   tap_step = m ? tap_sel_dr : tap_idle;
            tap_sel_dr: tap_step = m ? tap_sel_ir : tap_cap_dr;
            tap_cap_dr: tap_step = m ? tap_ex1_dr : tap_sh_dr;
            tap_sh_dr:  tap_step = m ? tap_ex1_dr : tap_sh_dr;
            tap_ex1_dr: tap_step = m ? tap_upd_dr : tap_pa_dr;
            tap_pa_dr:  tap_step = m ? tap_ex2_dr : tap_pa_dr;
            tap_ex2_dr: tap_step = m ? tap_upd_dr : tap_sh_dr;
            tap_upd_dr: tap_step = m ? tap_sel_dr : tap_idle;
            tap_sel_ir: tap_step = m ? tap_reset  : tap_cap_ir;
            tap_cap_ir: tap_step = m ? tap_ex1_ir : tap_sh_ir;
            tap_sh_ir:  tap_step = m ? tap_ex1_ir : tap_sh_ir;
            tap_ex1_ir: tap_step = m ? tap_upd_ir : tap_pa_ir;
            tap_pa_ir:  tap_step = m ? tap_ex2_ir : tap_pa_ir;
            tap_ex2_ir: tap_step = m ? tap_upd_ir : tap_sh_ir;
            tap_upd_ir: tap_step = m ? tap_sel_dr : tap_idle;
            default:    tap_step = tap_reset;
        endcase
    endfunction

    always_comb begin
        s_next      = s_reg;
        unlock_next = unlock_reg;
        tck_rise    = tck_q & ~s_reg.tck_prev;
        tck_fall    = ~tck_q & s_reg.tck_prev;
        s_next.tck_prev = tck_q;
        // a locked part sees every instruction but unlock as bypass
        if (s_reg.grant) begin
            eff_ir = s_reg.ir;
        end else if (s_reg.ir == `JSU_IR_UNLOCK) begin
            eff_ir = `JSU_IR_UNLOCK; // RULE9
        end else begin
            eff_ir = `JSU_IR_BYPASS; // RULE10
        end
        case (eff_ir)
            `JSU_IR_IDCODE:    msb = `JSU_MSB_IDCODE;
            `JSU_IR_ROUTER_ID: msb = `JSU_MSB_IDCODE;
            `JSU_IR_ROUTE:     msb = `JSU_MSB_ROUTE;
            `JSU_IR_BSCAN:     msb = `JSU_MSB_BSCAN;
            `JSU_IR_UNLOCK:    msb = `JSU_MSB_UNLOCK; // RULE6
            default:           msb = `JSU_MSB_BYPASS;
        endcase

        if (tck_rise) begin
            s_next.tap = tap_step(s_reg.tap, tms_q);
            case (s_reg.tap)
                tap_reset: s_next.ir = `JSU_IR_IDCODE;
                tap_cap_ir: s_next.ir_shift = `JSU_IR_CAPTURE;
                tap_sh_ir: s_next.ir_shift = {tdi_q, s_reg.ir_shift[3:1]};
                tap_upd_ir: s_next.ir = s_reg.ir_shift;
                tap_cap_dr: begin
                    s_next.dr = '0;
                    case (eff_ir)
                        `JSU_IR_IDCODE, `JSU_IR_ROUTER_ID:
                            s_next.dr[31:0] = ID_CODE; // RULE13
                        `JSU_IR_ROUTE:
                            s_next.dr[`JSU_ROUTE_LEN-1:0] = s_reg.route;
                        `JSU_IR_BSCAN:
                            s_next.dr[`JSU_BSC_LEN-1:0] = bsc_q; // RULE14
                        default: ;
                    endcase
                end
                tap_sh_dr: begin
                    // tdi enters at the top bit of the selected register
                    s_next.dr      = s_reg.dr >> 1; // RULE14
                    s_next.dr[msb] = tdi_q; // RULE14
                end
                tap_upd_dr: begin
                    case (eff_ir)
                        `JSU_IR_ROUTE:
                            s_next.route = s_reg.dr[`JSU_ROUTE_LEN-1:0];
                        `JSU_IR_BSCAN:
                            s_next.bsc_out = s_reg.dr[`JSU_BSC_LEN-1:0];
                        `JSU_IR_UNLOCK: unlock_next = s_reg.dr; // RULE6 RULE7
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end

        if (tck_fall) begin
            s_next.tdo_oe = (s_reg.tap == tap_sh_dr)
                          | (s_reg.tap == tap_sh_ir);
            if (s_reg.tap == tap_sh_ir) begin
                s_next.tdo = s_reg.ir_shift[0];
            end else if (s_reg.tap == tap_sh_dr) begin
                s_next.tdo = s_reg.dr[0]; // RULE14
            end
        end

        // compare on the value being written so the grant is not late
        combined = (visible_unlock_code ^ unlock_next) ^ `JSU_TIE_OFF; // RULE1 RULE15
        match = (combined == `JSU_REFERENCE) // RULE2 RULE3
              & (visible_unlock_code != '0); // RULE5
        s_next.grant = match;
        if (match) begin
            s_next.sec_en   = s_next.route[`JSU_N_SEC-1:0];
            s_next.test_en  = s_next.route[`JSU_ROUTE_TEST];
            s_next.bscan_en = s_next.route[`JSU_ROUTE_BSC];
        end else begin
            s_next.sec_en   = `JSU_SEC_SECURE; // RULE9
            s_next.test_en  = 1'b0; // RULE10
            s_next.bscan_en = 1'b0; // RULE10
        end

        // apb: answer in the access phase, no wait states
        setup   = apb_req.psel & ~apb_req.penable;
        rom_hit = (apb_req.paddr & `JSU_FRAME_MASK) == `JSU_ROM_BASE; // RULE11
        cpu_hit = (apb_req.paddr & `JSU_FRAME_MASK) == `JSU_CPU_BASE; // RULE11
        s_next.rsp = '0;
        if (setup) begin
            s_next.rsp.pready  = 1'b1;
            s_next.rsp.pslverr = ~(rom_hit | cpu_hit);
            s_next.rom_sel     = rom_hit;
            s_next.cpu_sel     = cpu_hit;
            // writes anywhere in the frames are dropped
            if (rom_hit & ~apb_req.pwrite) begin
                case (apb_req.paddr[11:2])
                    `JSU_ROM_IDX_CPU:  s_next.rsp.prdata = `JSU_ROM_VAL_CPU; // RULE12
                    `JSU_ROM_IDX_RSVA: s_next.rsp.prdata = `JSU_ROM_VAL_RSVA; // RULE12
                    `JSU_ROM_IDX_RSVB: s_next.rsp.prdata = `JSU_ROM_VAL_RSVB; // RULE12
                    `JSU_ROM_IDX_OVL:  s_next.rsp.prdata = `JSU_ROM_VAL_OVL; // RULE12
                    `JSU_ROM_IDX_END:  s_next.rsp.prdata = `JSU_ROM_VAL_END; // RULE12
                    default:           s_next.rsp.prdata = 32'h0000_0000; // RULE11
                endcase
            end
        end else if (s_reg.rsp.pready) begin
            s_next.rom_sel = 1'b0;
            s_next.cpu_sel = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            s_reg <= S_INIT;
        end else begin
            s_reg <= s_next;
        end
    end

    // only power-on clears the scan code, so a warm reset keeps unlock
    always_ff @(posedge clock or negedge por_q) begin
        if (!por_q) begin
            unlock_reg <= '0; // RULE8
        end else begin
            unlock_reg <= unlock_next;
        end
    end

    assign tdo                    = s_reg.tdo;
    assign tdo_oe                 = s_reg.tdo_oe;
    assign unlock_grant           = s_reg.grant;
    assign sec_tap_enable         = s_reg.sec_en;
    assign test_tap_enable        = s_reg.test_en;
    assign bscan_enable           = s_reg.bscan_en;
    assign bsc_pin_out            = s_reg.bsc_out;
    assign apb_rsp                = s_reg.rsp;
    assign debug_rom_frame_select = s_reg.rom_sel;
    assign cpu_debug_frame_select = s_reg.cpu_sel;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_q);

    a_xor_compare: assert property ($past(rst_q) |-> // RULE1 RULE2
        unlock_grant == $past((((visible_unlock_code ^ unlock_next)
            ^ `JSU_TIE_OFF) == `JSU_REFERENCE) && visible_unlock_code != '0))
        else $error("unlock grant differs from code comparison");
    a_factory_open: assert property (visible_unlock_code == `JSU_FACTORY_CODE && unlock_next == '0 |=> unlock_grant) // RULE3
        else $error("factory code did not unlock");
    a_zero_code_lock: assert property (visible_unlock_code == '0 |=> !unlock_grant) // RULE5
        else $error("all-zero code unlocked the part");
    a_unlock_load: assert property (tck_rise && s_reg.tap == tap_upd_dr && eff_ir == `JSU_IR_UNLOCK |=> unlock_reg == $past(s_reg.dr)) // RULE6
        else $error("unlock register not loaded on update");
    a_unlock_keep: assert property (@(posedge clock) disable iff (!por_q) !rst_q |=> $stable(unlock_reg)) // RULE8
        else $error("warm reset disturbed unlock register");
    a_secured_gate: assert property ( // RULE9 RULE10
        $past(rst_q) && !unlock_grant |-> sec_tap_enable == `JSU_SEC_SECURE
            && !test_tap_enable && !bscan_enable)
        else $error("tap exposed while secured");
    a_unmapped_zero: assert property (setup && rom_hit && apb_req.paddr[11:2] > `JSU_ROM_IDX_END |=> apb_rsp.pready && apb_rsp.prdata == 32'h0000_0000) // RULE11
        else $error("unimplemented rom word not zero");
    a_rom_pointer: assert property (setup && !apb_req.pwrite && rom_hit && apb_req.paddr[11:2] == `JSU_ROM_IDX_OVL |=> apb_rsp.prdata == `JSU_ROM_VAL_OVL ##1 !apb_rsp.pready) // RULE12
        else $error("overlay pointer word wrong");
    a_idcode_same: assert property (tck_rise && s_reg.tap == tap_cap_dr && (eff_ir == `JSU_IR_IDCODE || eff_ir == `JSU_IR_ROUTER_ID) |=> s_reg.dr[31:0] == ID_CODE) // RULE13
        else $error("id capture mismatch");
    a_bscan_shift: assert property (tck_rise && s_reg.tap == tap_sh_dr && eff_ir == `JSU_IR_BSCAN |=> s_reg.dr[`JSU_MSB_BSCAN] == $past(tdi_q)) // RULE14
        else $error("boundary chain did not take tdi");
    a_grant_prompt: assert property (tck_rise && s_reg.tap == tap_upd_dr && eff_ir == `JSU_IR_UNLOCK && ((visible_unlock_code ^ s_reg.dr ^ `JSU_TIE_OFF) == `JSU_REFERENCE) && visible_unlock_code != '0 |=> unlock_grant) // RULE15
        else $error("grant late after unlock update");

    c_unlock_scan: cover property (!unlock_grant ##1 unlock_grant);
    c_rom_read: cover property (setup && rom_hit && !apb_req.pwrite);
    c_bad_addr: cover property (apb_rsp.pready && apb_rsp.pslverr);
    c_bscan_upd: cover property (s_reg.tap == tap_upd_dr && eff_ir == `JSU_IR_BSCAN);
endmodule // jsu_top

// ---- bench/jsu_jtag_model.sv ----
// jtag debugger model that paces the tap pins of the block
`timescale 1ns/10ps
module jsu_jtag_model (
    // pacing clock
    input  wire logic clock,
    // jtag pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    // 8 clocks high and 8 low give the 160 ns link period
    localparam int HALF = 8;

    int oe_miss = 0;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one tck period; tck stands low between frames
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (HALF) @(negedge clock);
        q = tdo;
        tck = 1'b1;
        repeat (HALF) @(negedge clock);
        tck = 1'b0;
    endtask

    // idle, shift len bits lsb first, update, back to idle
    task automatic scan(input logic is_ir, input int len,
                        input logic [127:0] din, output logic [127:0] dout);
        logic q;
        dout = '0;
        tick(1'b0, 1'b0, q);
        tick(1'b1, 1'b0, q);
        if (is_ir) begin
            tick(1'b1, 1'b0, q);
        end
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < len; i++) begin
            tick(i == len - 1, din[i], q);
            dout[i] = q;
            if (tdo_oe !== 1'b1) begin
                oe_miss++;
            end
        end
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask
endmodule // jsu_jtag_model

// ---- bench/jsu_top_tb.sv ----
// self-checking bench for the security unlock and debug rom block
`timescale 1ns/10ps
module jsu_top_tb import jsu_pkg::*; ;
    localparam logic [31:0] ID = 32'h0000_1001; // arbitrary value

    logic                   clock;
    logic                   rst_n;
    logic                   power_on_reset_n;
    logic                   tck;
    logic                   tms;
    logic                   tdi;
    logic                   tdo;
    logic                   tdo_oe;
    logic [127:0]           otp;
    logic                   unlock_grant;
    logic [3:0]             sec_en;
    logic                   test_en;
    logic                   bscan_en;
    logic [7:0]             pin_in;
    logic [7:0]             pin_out;
    jsu_apb_req_type        apb_req;
    jsu_apb_rsp_type        apb_rsp;
    logic                   rom_sel;
    logic                   cpu_sel;
    int                     num_errors = 0;
    int                     check_count = 0;

    jsu_top #(.ID_CODE(ID)) dut (
        .clock(clock), .rst_n(rst_n), .power_on_reset_n(power_on_reset_n),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .visible_unlock_code(otp), .unlock_grant(unlock_grant),
        .sec_tap_enable(sec_en), .test_tap_enable(test_en),
        .bscan_enable(bscan_en), .bsc_pin_in(pin_in),
        .bsc_pin_out(pin_out), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .debug_rom_frame_select(rom_sel), .cpu_debug_frame_select(cpu_sel)
    );

    jsu_jtag_model jtag (
        .clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe)
    );

    always #5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [127:0] exp,
                         input logic [127:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic pulse(input logic por);
        if (por) begin
            power_on_reset_n = 1'b0;
        end else begin
            rst_n = 1'b0;
        end
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        power_on_reset_n = 1'b1;
        repeat (6) @(negedge clock);
    endtask

    // entered at a falling edge; holds the request until pready is seen
    task automatic apb(input logic wr, input logic [31:0] addr,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic [2:0] flags);
        int n;
        apb_req = '{1'b1, 1'b0, wr, addr, wd};
        @(negedge clock);
        apb_req.penable = 1'b1;
        n = 0;
        while (apb_rsp.pready !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        check("pready", 1'b1, apb_rsp.pready);
        rd = apb_rsp.prdata;
        flags = {apb_rsp.pslverr, rom_sel, cpu_sel};
        @(negedge clock);
        apb_req = '0;
        // one idle cycle so the next call never re-drives this time step
        @(negedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_rom;
        logic [31:0] rd;
        logic [2:0]  fl;
        logic [31:0] a [9] = '{32'hffa0_0000, 32'hffa0_0004, 32'hffa0_0008,
            32'hffa0_000c, 32'hffa0_0010, 32'hffa0_0ffc, 32'hffa0_1000,
            32'hffa0_1ffc, 32'hffa0_2000};
        logic [31:0] d [9] = '{32'h0000_1003, 32'h0000_2002, 32'h0000_3002,
            32'h0000_4003, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        logic [2:0]  f [9] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1,
            3'h1, 3'h4};
        apb(1'b1, 32'hffa0_0000, 32'hffff_ffff, rd, fl);
        check("write flags", 3'h2, fl);
        apb(1'b1, 32'hffa0_1004, 32'hffff_ffff, rd, fl);
        check("write flags", 3'h1, fl);
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, a[i], 32'h0, rd, fl);
            check("frame data", d[i], rd);
            check("frame flags", f[i], fl);
        end
    endtask

    task automatic test_id;
        logic [127:0] q;
        jtag.scan(1'b1, 4, `JSU_IR_IDCODE, q);
        check("ir capture", 4'h1, q[3:0]);
        jtag.scan(1'b0, 32, 128'h0, q);
        check("jtag id", ID, q[31:0]);
        jtag.scan(1'b1, 4, `JSU_IR_ROUTER_ID, q);
        jtag.scan(1'b0, 32, 128'h0, q);
        check("router id", ID, q[31:0]);
    endtask

    task automatic test_route;
        logic [127:0] q;
        jtag.scan(1'b1, 4, `JSU_IR_ROUTE, q);
        jtag.scan(1'b0, 6, 128'h35, q);
        check("open gating", 6'h35, {bscan_en, test_en, sec_en});
        jtag.scan(1'b1, 4, `JSU_IR_BSCAN, q);
        jtag.scan(1'b0, 8, 128'h3c, q);
        check("bscan capture", 8'h96, q[7:0]);
        check("bscan update", 8'h3c, pin_out);
    endtask

    task automatic test_secured;
        logic [127:0] q;
        otp = ~(128'h1 << 5);
        repeat (3) @(negedge clock);
        check("secured grant", 1'b0, unlock_grant);
        check("secured gating", 6'h04, {bscan_en, test_en, sec_en});
        jtag.scan(1'b1, 4, `JSU_IR_IDCODE, q);
        jtag.scan(1'b0, 8, 128'ha5, q);
        check("bypass out", 8'h4a, q[7:0]);
        jtag.scan(1'b1, 4, `JSU_IR_BSCAN, q);
        jtag.scan(1'b0, 8, 128'h00, q);
        check("bscan blocked", 8'h3c, pin_out);
    endtask

    task automatic unlock_scan(input logic [127:0] key);
        logic [127:0] q;
        jtag.scan(1'b1, 4, `JSU_IR_UNLOCK, q);
        jtag.scan(1'b0, 128, key, q);
        check("unlock capture", 128'h0, q);
    endtask

    task automatic test_unlock;
        unlock_scan(128'h1 << 4);
        check("wrong key grant", 1'b0, unlock_grant);
        unlock_scan(otp ^ `JSU_FACTORY_CODE);
        check("key grant", 1'b1, unlock_grant);
        check("open again", 6'h35, {bscan_en, test_en, sec_en});
    endtask

    task automatic test_resets;
        pulse(1'b0);
        check("grant kept", 1'b1, unlock_grant);
        pulse(1'b1);
        check("grant cleared", 1'b0, unlock_grant);
    endtask

    task automatic test_zero_code;
        otp = 128'h0;
        unlock_scan(`JSU_FACTORY_CODE);
        check("zero code grant", 1'b0, unlock_grant);
        check("zero code gating", 6'h04, {bscan_en, test_en, sec_en});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        otp = `JSU_FACTORY_CODE;
        pin_in = 8'h96;
        apb_req = '0;
        pulse(1'b1);
        check("factory grant", 1'b1, unlock_grant);
        test_rom();
        test_id();
        test_route();
        test_secured();
        test_unlock();
        test_resets();
        test_zero_code();
        check("oe in shift", 0, jtag.oe_miss);
        final_report();
    end

    // whole run takes about 100 us; allow more than three times that
    initial begin
        #400000;
        num_errors++;
        $display("watchdog expired");
        final_report();
    end
endmodule // jsu_top_tb
